// [bench/tmc_group_inserter_test.sv]
// Purpose: Self-checking bench for the traffic group inserter
// Assumes: Provider model drives the byte port, bench drives slots
// Notes: Port timeout shortened through TIMEOUT_CYC
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Bench top
module tmc_group_inserter_test;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic uecp_enable_i = 1'b1;
  tmc_pkg::addr_cfg_t addr_cfg_i = '0;
  logic batch_mode_i = 1'b0;
  logic batch_slot_i = 1'b0;
  logic time_due_i = 1'b0;
  logic slot_req_i = 1'b0;
  logic [7:0] rx_byte;
  logic rx_valid, rx_ready, ins_valid, ascii_valid;
  logic [7:0] ascii_byte;
  tmc_pkg::group_t ins_grp;
  tmc_pkg::group_t got[$];
  int got_slot[$];
  logic [7:0] asc[$];
  int slot_n = 0;
  int cyc = 0;
  int n_mismatch = 0;
  int compares = 0;

  tmc_provider p (.ref_clk_i(ref_clk_i), .rx_ready_i(rx_ready), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid));

  tmc_group_inserter #(.TIMEOUT_CYC(200)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .uecp_enable_i(uecp_enable_i), .addr_cfg_i(addr_cfg_i), .batch_mode_i(batch_mode_i),
    .batch_slot_i(batch_slot_i), .time_due_i(time_due_i), .slot_req_i(slot_req_i),
    .ins_valid_o(ins_valid), .ins_grp_o(ins_grp), .ascii_byte_o(ascii_byte),
    .ascii_valid_o(ascii_valid));

  // 50 MHz clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // Monitor; slot index is recorded before this edge's request counts
  always @(posedge ref_clk_i) begin
    if (ins_valid === 1'b1) begin
      got.push_back(ins_grp);
      got_slot.push_back(slot_n);
    end
    if (slot_req_i) slot_n++;
    if (ascii_valid === 1'b1) asc.push_back(ascii_byte);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // One record of eight message bytes; zero checksum is never checked
  task automatic rec(input logic [15:0] a, input logic [7:0] c, input logic [7:0] b1,
    input logic [15:0] b4);
    logic [7:0] m[16];
    m = '{8'hFE, a[15:8], a[7:0], 8'h00, 8'h08, c, b1, b1, 8'h07, 8'hC8, 8'h01,
      b4[15:8], b4[7:0], 8'h00, 8'h00, 8'hFF};
    // Body bytes FD..FF go out escaped as FD 00..02
    foreach (m[i]) begin
      if (i > 0 && i < 15 && m[i] >= 8'hFD) begin
        p.put(8'hFD);
        p.put(m[i] - 8'hFD);
      end else begin
        p.put(m[i]);
      end
    end
    p.idle();
    repeat (12) @(posedge ref_clk_i) #1;
  endtask : rec

  // Request a slot every cycle, as a running stream does
  task automatic run_slots(input int n);
    got.delete();
    got_slot.delete();
    repeat (n) begin
      slot_req_i = 1'b1;
      @(posedge ref_clk_i) #1;
    end
    slot_req_i = 1'b0;
    repeat (3) @(posedge ref_clk_i) #1;
  endtask : run_slots

  // every queued code, traffic repeats spaced
  // last, a code 24 record with FF FD in block 4 checks that escaped bytes come back unstuffed
  task automatic t_codes();
    logic [7:0] codes[4] = '{8'h24, 8'h30, 8'h40, 8'h42};
    foreach (codes[i]) begin
      rec(16'h0000, codes[i], 8'h05, 16'(i));
      run_slots(12);
      check(64'(got.size()), (codes[i] == 8'h30) ? 64'd2 : 64'd1);
      check(64'(got[0].gtype), (codes[i] == 8'h30) ? 64'h10 : 64'h05);
      check(64'({got[0].b2, got[0].b3, got[0].b4}), 64'({5'h07, 16'hC801, 16'(i)}));
      if (codes[i] == 8'h30) check(64'(got_slot[1] - got_slot[0]), 64'd4);
    end
    rec(16'h0000, 8'h24, 8'h06, 16'hFFFD);
    run_slots(4);
    check(64'(got.size()), 64'd1);
    check(64'(got[0].b4), 64'hFFFD);
  endtask : t_codes

  task automatic t_addr();
    logic [15:0] a[6] = '{16'h0143, 16'h0183, 16'h0007, 16'h0000, 16'h0003, 16'h0140};
    logic ok[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    addr_cfg_i = '{site_a: 10'h005, site_b: 10'h009, enc_a: 6'h03, enc_b: 6'h04};
    foreach (a[i]) begin
      rec(a[i], 8'h24, 8'h06, 16'(i));
      run_slots(4);
      check(64'(got.size()), 64'(ok[i]));
    end
    addr_cfg_i = '0;
  endtask : t_addr

  // seventeen groups into sixteen places, order kept
  task automatic t_full();
    for (int i = 0; i < 17; i++) rec(16'h0000, 8'h24, 8'h06, 16'(i));
    run_slots(24);
    check(64'(got.size()), 64'd16);
    foreach (got[i]) check(64'(got[i].b4), 64'(i));
  endtask : t_full

  // time group holds the queue back, batch mode until its batch slot
  task automatic t_hold();
    rec(16'h0000, 8'h24, 8'h06, 16'h0033);
    time_due_i = 1'b1;
    run_slots(2);
    check(64'(got.size()), 64'd0);
    time_due_i = 1'b0;
    batch_mode_i = 1'b1;
    run_slots(2);
    check(64'(got.size()), 64'd0);
    batch_slot_i = 1'b1;
    run_slots(1);
    check(64'(got.size()), 64'd1);
    batch_mode_i = 1'b0;
    batch_slot_i = 1'b0;
  endtask : t_hold

  // record bytes hidden, records ignored while disabled
  task automatic t_ascii();
    int n;
    asc.delete();
    check(64'(rx_ready), 64'd1);
    p.put(8'h41);
    p.idle();
    rec(16'h0000, 8'h24, 8'h06, 16'h0001);
    p.put(8'h42);
    p.idle();
    repeat (4) @(posedge ref_clk_i) #1;
    check(64'(asc.size()), 64'd2);
    check(64'({asc[0], asc[1]}), 64'h4142);
    run_slots(2);
    uecp_enable_i = 1'b0;
    rec(16'h0000, 8'h24, 8'h06, 16'h0002);
    run_slots(4);
    check(64'(got.size()), 64'd0);
    uecp_enable_i = 1'b1;
    n = asc.size();
    p.put(8'hFE);
    p.idle();
    repeat (210) @(posedge ref_clk_i) #1;
    p.put(8'h43);
    p.idle();
    repeat (4) @(posedge ref_clk_i) #1;
    check(64'(asc.size()), 64'(n + 1));
    check(64'(asc[asc.size() - 1]), 64'h43);
  endtask : t_ascii

  // Main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    @(posedge ref_clk_i) #1;
    t_codes();
    t_addr();
    t_full();
    t_hold();
    t_ascii();
    stop_test();
  end
endmodule : tmc_group_inserter_test
`default_nettype wire

// [bench/tmc_provider.sv]
// Purpose: Traffic data provider model feeding records byte by byte
// Assumes: Called just after a rising edge of ref_clk_i
// Notes: Record content is chosen by the caller; this model only drives bytes
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Provider byte driver
module tmc_provider (
  input wire logic ref_clk_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o
);
  // Idle at time zero
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
  end

  // Offer one byte and hold it until the edge that takes it
  task automatic put(input logic [7:0] b);
    rx_byte_o = b;
    rx_valid_o = 1'b1;
    do @(posedge ref_clk_i); while (rx_ready_i !== 1'b1);
    #1;
  endtask : put

  // Released line shows the inverse, so a stale byte never looks valid
  task automatic idle();
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
    @(posedge ref_clk_i) #1;
  endtask : idle
endmodule : tmc_provider
`default_nettype wire

// [hw/tmc_group_inserter.sv]
// Purpose: Record parser, shared group queue and output slot scheduler
// Assumes: Serial bytes arrive already deframed on the system clock
// Notes: Checksum and sequence counter are not checked here
`timescale 1ns/100ps
`default_nettype none
`include "tmc_params.svh"

// ==========================================================
// Generic queue with valid/ready on both sides
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic wr;
  logic rd;
  assign in_ready_o = (count_o != (AW+1)'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o = mem[rd_ptr];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;
  // Storage has no reset; contents are qualified by count
  always_ff @(posedge ref_clk_i) begin
    if (wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  // Pointers and fill level
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end else begin
      if (wr) wr_ptr <= wr_ptr + 1'b1;
      if (rd) rd_ptr <= rd_ptr + 1'b1;
      count_o <= count_o + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : sync_fifo

// ==========================================================
// Notes on behaviour
// - Apply a record only when site and encoder addresses are both accepted.
// - Keep at least three other groups between any two traffic groups.
// - Groups from codes 24, 30, 40, 42 go into the shared queue.
// - Keep the queue transparent; traffic groups still wait for the three-slot gap.
// - Queue is first-in first-out, sixteen groups, repeats in one entry.
// - Address is 10-bit site high, 6-bit encoder low; zero is global.
// - Transparent queue output goes first, yielding to time groups and to the traffic gap.
// - Start byte hides bytes from ASCII until stop, length or timeout.
module tmc_group_inserter #(
  parameter longint TIMEOUT_CYC = `TIMEOUT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic uecp_enable_i,
  input wire tmc_pkg::addr_cfg_t addr_cfg_i,
  input wire logic batch_mode_i,
  input wire logic batch_slot_i,
  input wire logic time_due_i,
  input wire logic slot_req_i,
  output logic ins_valid_o,
  output tmc_pkg::group_t ins_grp_o,
  output logic [7:0] ascii_byte_o,
  output logic ascii_valid_o
);
  logic [7:0] b_data;
  logic b_valid;
  logic b_take;
  logic [3:0] b_count;
  tmc_pkg::parse_t st;
  tmc_pkg::group_t new_grp;
  tmc_pkg::group_t head;
  logic push;
  logic g_ready;
  logic head_valid;
  logic pop;
  logic [4:0] g_count;
  logic esc;
  logic [7:0] val;
  logic [8:0] idx;
  logic [15:0] addr;
  logic [7:0] mfl;
  logic [7:0] message_element_code;
  logic [7:0] b1;
  logic [39:0] tail;
  logic [32:0] idle_cnt;
  logic frame_ok;
  logic mec_ok;
  logic [1:0] gap;
  logic [1:0] rep_done;
  logic eligible;
  // Byte queue in front of the parser; it is read every cycle, so rx_ready_o never drops
  sync_fifo #(.WIDTH(8), .DEPTH(`BYTE_DEPTH)) u_byte_q (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .in_data_i(rx_byte_i), .in_valid_i(rx_valid_i), .in_ready_o(rx_ready_o),
    .out_data_o(b_data), .out_valid_o(b_valid), .out_ready_i(b_take),
    .count_o(b_count)
  );
  // Stop byte is taken as its group is pushed; a stall would push it again
  assign b_take = b_valid;
  function automatic logic addr_ok(input logic [15:0] a, input tmc_pkg::addr_cfg_t c);
    logic [9:0] s;
    logic [5:0] e;
    s = a[`SITE_MSB:`SITE_LSB];
    e = a[`ENC_MSB:0];
    return (s == 10'h000 || s == c.site_a || s == c.site_b) &&
           (e == 6'h00 || e == c.enc_a || e == c.enc_b);
  endfunction : addr_ok
  // Unstuff escaped bytes; escape values 0..2 map to FD..FF
  assign val = esc ? (`REC_ESC + b_data) : b_data;
  assign mec_ok = (message_element_code == `MEC_FREE) || (message_element_code == `MEC_TRAFFIC) ||
                  (message_element_code == `MEC_ODA_CFG) || (message_element_code == `MEC_ODA_FREE);
  // Exact length: address, counter, length, message field, checksum
  assign frame_ok = st == tmc_pkg::PS_BODY && b_valid && !esc && b_data == `REC_STOP &&
                    mfl >= 8'h06 && idx == 9'(mfl) + 9'h006;
  // Build the queue entry from the element code, first data byte and last five message bytes
  always_comb begin
    new_grp.is_tmc = (message_element_code == `MEC_TRAFFIC);
    new_grp.gtype = (message_element_code == `MEC_TRAFFIC) ? `TRAFFIC_GTYPE : b1[4:0];
    new_grp.rep = (message_element_code == `MEC_TRAFFIC) ? b1[1:0] :
                  (message_element_code == `MEC_FREE) ? {1'b0, b1[6]} : 2'h0;
    new_grp.b2 = tail[36:32];
    new_grp.b3 = tail[31:16];
    new_grp.b4 = tail[15:0];
  end
  // nothing is applied while reception is off
  assign push = frame_ok && mec_ok && addr_ok(addr, addr_cfg_i) && uecp_enable_i;
  // record framing, length limit and port timeout
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= tmc_pkg::PS_IDLE;
      esc <= 1'b0;
      idx <= '0;
      idle_cnt <= '0;
    end else if (st == tmc_pkg::PS_IDLE) begin
      esc <= 1'b0;
      idx <= '0;
      idle_cnt <= '0;
      if (b_take && uecp_enable_i && b_data == `REC_START) st <= tmc_pkg::PS_BODY;
    end else if (b_take) begin
      idle_cnt <= '0;
      if (b_data == `REC_START) begin
        idx <= '0;
        esc <= 1'b0;
      end else if (b_data == `REC_STOP || idx == `REC_MAX_LEN - 9'h001) begin
        st <= tmc_pkg::PS_IDLE;
      end else if (b_data == `REC_ESC && !esc) begin
        esc <= 1'b1;
      end else begin
        esc <= 1'b0;
        idx <= idx + 9'h001;
      end
    end else if (!push) begin
      // Quiet port ends the record so ASCII is not locked out for good
      if (idle_cnt == 33'(TIMEOUT_CYC - 1)) st <= tmc_pkg::PS_IDLE;
      idle_cnt <= idle_cnt + 33'h1;
    end
  end

  // Record field capture
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr <= '0;
      mfl <= '0;
      message_element_code <= '0;
      b1 <= '0;
      tail <= '0;
    end else if (st == tmc_pkg::PS_BODY && b_take && !(b_data == `REC_ESC && !esc)) begin
      case (idx)
        9'h000: addr[15:8] <= val;
        9'h001: addr[7:0] <= val;
        9'h003: mfl <= val;
        9'h004: message_element_code <= val;
        9'h005: b1 <= val;
        default: ;
      endcase
      if (idx >= 9'h005 && idx < 9'(mfl) + 9'h004) tail <= {tail[31:0], val};
    end
  end

  // Bytes outside records reach the ASCII interpreter
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ascii_valid_o <= 1'b0;
      ascii_byte_o <= '0;
    end else begin
      ascii_valid_o <= b_take && st == tmc_pkg::PS_IDLE &&
                       !(uecp_enable_i && b_data == `REC_START);
      ascii_byte_o <= b_data;
    end
  end

  sync_fifo #(.WIDTH($bits(tmc_pkg::group_t)), .DEPTH(`GROUP_DEPTH)) u_group_q (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .in_data_i(new_grp), .in_valid_i(push), .in_ready_o(g_ready),
    .out_data_o(head), .out_valid_o(head_valid), .out_ready_i(pop),
    .count_o(g_count)
  );

  // time groups first, then queue at once or at batch slot
  assign eligible = slot_req_i && !time_due_i && head_valid &&
                    (!batch_mode_i || batch_slot_i) && (!head.is_tmc || gap == `TRAFFIC_GAP);
  // Repeats keep the entry until its last send
  assign pop = eligible && rep_done == head.rep;

  // Slot answer and repeat bookkeeping
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ins_valid_o <= 1'b0;
      ins_grp_o <= '0;
      rep_done <= '0;
    end else begin
      ins_valid_o <= eligible;
      if (eligible) ins_grp_o <= head;
      if (pop) rep_done <= '0;
      else if (eligible) rep_done <= rep_done + 2'h1;
    end
  end

  // count slots requested since last traffic group, up to three
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= `TRAFFIC_GAP;
    end else if (eligible && head.is_tmc) begin
      gap <= 2'h0;
    end else if (slot_req_i && gap != `TRAFFIC_GAP) begin
      gap <= gap + 2'h1;
    end
  end

  // ==========================================================
  // Checks
  logic [2:0] since_tmc;
  // Slots since the last traffic group; the slot in its pulse cycle counts
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) since_tmc <= 3'h3;
    else if (ins_valid_o && ins_grp_o.is_tmc) since_tmc <= {2'h0, slot_req_i};
    else if (slot_req_i && since_tmc != 3'h7) since_tmc <= since_tmc + 3'h1;
  end

  addr_match_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    u_group_q.wr |-> addr_ok(addr, addr_cfg_i) && uecp_enable_i)
    else $error("group queued from unaccepted address");
  tmc_gap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ins_valid_o && ins_grp_o.is_tmc |-> $past(since_tmc) >= 3'h3)
    else $error("traffic groups closer than three groups");
  mec_route_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    frame_ok && mec_ok && addr_ok(addr, addr_cfg_i) && uecp_enable_i && g_ready
    |=> g_count == $past(g_count) + 5'h01 - 5'($past(pop)))
    else $error("queued element code did not enter queue");
  queue_fast_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    slot_req_i && !batch_mode_i && !time_due_i && head_valid && !head.is_tmc
    |=> ins_valid_o && ins_grp_o == $past(head))
    else $error("transparent queue head not sent");
  fifo_depth_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    g_count <= 5'h10)
    else $error("group queue over sixteen");
  global_addr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    frame_ok && mec_ok && addr == 16'h0000 && uecp_enable_i && g_ready |-> u_group_q.wr)
    else $error("global address refused");
  time_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    slot_req_i && time_due_i |=> !ins_valid_o)
    else $error("queue group displaced a time group");
  ascii_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ascii_valid_o |-> $past(st) == tmc_pkg::PS_IDLE &&
    ($past(b_data) != `REC_START || !$past(uecp_enable_i)))
    else $error("record byte leaked to ASCII");
  full_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    push && !g_ready && !pop |=> g_count == 5'h10 && $stable(head))
    else $error("full queue changed on push");
endmodule : tmc_group_inserter
`default_nettype wire

// [hw/tmc_params.svh]
// Purpose: Constants for the traffic group inserter
// Assumes: 50 MHz system clock
// Notes: Record framing bytes, message element codes, limits and timing
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
`define REC_START 8'hFE
`define REC_STOP 8'hFF
`define REC_ESC 8'hFD
`define MEC_FREE 8'h24
`define MEC_TRAFFIC 8'h30
`define MEC_ODA_CFG 8'h40
`define MEC_ODA_FREE 8'h42
`define TRAFFIC_GTYPE 5'h10
`define REC_MAX_LEN 9'h104
`define TRAFFIC_GAP 2'h3
`define GROUP_DEPTH 16
`define BYTE_DEPTH 8
`define SITE_MSB 15
`define SITE_LSB 6
`define ENC_MSB 5
`define PORT_TIMEOUT_S 120
`define CLK_HZ 50000000
`define TIMEOUT_CYCLES (64'd`PORT_TIMEOUT_S * 64'd`CLK_HZ)
`endif

// [hw/tmc_pkg.sv]
// Purpose: Types for the traffic group inserter
// Assumes: Nothing beyond the params header
// Notes: A group holds blocks 2 to 4 less the fields the encoder fills in
package tmc_pkg;
  typedef struct packed {
    logic is_tmc;
    logic [1:0] rep;
    logic [4:0] gtype;
    logic [4:0] b2;
    logic [15:0] b3;
    logic [15:0] b4;
  } group_t;
  typedef struct packed {
    logic [9:0] site_a;
    logic [9:0] site_b;
    logic [5:0] enc_a;
    logic [5:0] enc_b;
  } addr_cfg_t;
  typedef enum logic {PS_IDLE, PS_BODY} parse_t;
endpackage : tmc_pkg
